/* File: design/tape_read_pkg.sv */
package tape_read_pkg;
    localparam int TRACKS = 9;
    localparam int GROUP_W = 3;
    localparam int GROUPS = 3;
    localparam int BIT_PARITY = 8;
    // AXI4-Lite register byte offsets
    localparam logic [7:0] OFF_CONTROL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h08;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h0c;
    localparam logic [7:0] OFF_READ_REG = 8'h10;
    // Control bits
    localparam int CTL_READ = 0;
    localparam int CTL_WRITE = 1;
    localparam int CTL_FWD = 2;
    localparam int CTL_REV = 3;
    // Status bits
    localparam int ST_PRESENT = 0;
    localparam int ST_ODD = 1;
    localparam int ST_SHIFT = 2;
    localparam int ST_BYTE_OK = 3;
    localparam int ST_CHK_ERR = 4;
    // Interrupt bits
    localparam int IRQ_PE = 0;
    localparam int IRQ_CHAR = 1;
    localparam int IRQ_W = 2;
    localparam logic [31:0] CTL_RESET = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        PE_IDLE = 2'b00,
        PE_HOLD = 2'b01,
        PE_WAIT = 2'b10
    } pe_state_t;
endpackage

/* File: design/edge_detect.sv */
`timescale 1ns/1ps
module edge_detect
(
    // Clock and control
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic enable_i,
    // Level in, edges out
    input wire logic level_i,
    output logic rise_o,
    output logic fall_o
);
    logic level_q;
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
            level_q <= 1'b0;
        else if (enable_i)
            level_q <= level_i;
    end
    assign rise_o = enable_i & level_i & ~level_q;
    assign fall_o = enable_i & ~level_i & level_q;
endmodule

/* File: design/byte_parity.sv */
`timescale 1ns/1ps
module byte_parity
    import tape_read_pkg::*;
(
    // Byte under check
    input wire logic [tape_read_pkg::TRACKS-1:0] byte_i,
    // Group and byte results
    output logic [tape_read_pkg::GROUPS-1:0] group_ok_o,
    output logic byte_parity_ok_o
);
    genvar g;
    generate
        for (g = 0; g < GROUPS; g++)
        begin : grp
            assign group_ok_o[g] = ^byte_i[g*GROUP_W +: GROUP_W];
        end
    endgenerate
    assign byte_parity_ok_o = ^group_ok_o;
endmodule

/* File: design/tape_read_char_parity_check.sv */
// Functional notes
// - Read bit line sets assembly bit on clock
// - End strobe fall copies assembly to read
// - Clear strobe empties assembly on next clock
// - Present flag set when clear strobe falls
// - Shift flag fall clears present flag when reading
// - Shift flag set/cleared per memory cycle
// - Three groups of three, odd flag each
// - Groups combine into byte odd parity
// - Parity error on bad data byte
// - Forward read toggles byte count parity
// - Backward read presets count, data toggles
// - Forward check char parity versus count
// - Backward count flag checked at gate
// - Error drives data bus and pattern
// - Nine bit registers cleared by reset
// - Counter raises end strobe after window (counter is external; end strobe is an input here)
// - Longitudinal character never parity checked
`timescale 1ns/1ps
module tape_read_char_parity_check
    import tape_read_pkg::*;
#(
    parameter int TRACK_N = tape_read_pkg::TRACKS
)
(
    // Clock, reset, enable
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic clk_en_i,
    // Read channel side
    input wire logic [TRACK_N-1:0] read_bit_line_i,
    input wire logic channel_clock_i,
    input wire logic assembly_end_strobe_i,
    input wire logic assembly_clear_strobe_i,
    input wire logic shift_set_i,
    input wire logic shift_end_i,
    input wire logic check_char_time_i,
    input wire logic longitudinal_char_time_i,
    input wire logic record_end_gate_i,
    input wire logic register_clear_i,
    input wire logic count_clear_i,
    // Outputs to data bus and error pattern register
    output logic [TRACK_N-1:0] data_bus_o,
    output logic parity_error_out_o,
    output logic ep_parity_in_o,
    output logic check_char_parity_error_o,
    output logic char_present_flag_o,
    output logic [TRACK_N-1:0] read_reg_o,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Interrupt
    output logic irq_o
);
    import tape_read_pkg::*;

    logic [TRACK_N-1:0] assembly_bit;
    logic [TRACK_N-1:0] read_reg_bit;
    logic char_present_flag;
    logic shift_flag;
    logic odd_count;
    logic clear_pending;
    logic pe_q;
    pe_state_t pe_state;
    logic [31:0] control;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic [7:0] aw_addr;
    logic aw_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_held;
    logic [31:0] rdata;
    logic rvalid;
    logic [1:0] rresp;
    logic bvalid;
    logic [1:0] bresp;

    wire read_active = control[CTL_READ];
    wire write_active = control[CTL_WRITE];
    wire forward_dir = control[CTL_FWD];
    wire backward_dir = control[CTL_REV];
    wire [GROUPS-1:0] group_ok;
    wire byte_parity_ok;
    wire ch_fall;
    wire end_fall;
    wire clr_fall;
    wire clr_rise;
    wire present_fall;
    wire shift_fall;
    wire gate_rise;

    byte_parity u_parity
    (
        .byte_i(read_reg_bit),
        .group_ok_o(group_ok),
        .byte_parity_ok_o(byte_parity_ok)
    );

    edge_detect u_ch
    (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .enable_i(clk_en_i),
        .level_i(channel_clock_i), .rise_o(), .fall_o(ch_fall)
    );
    edge_detect u_end
    (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .enable_i(clk_en_i),
        .level_i(assembly_end_strobe_i), .rise_o(), .fall_o(end_fall)
    );
    edge_detect u_clr
    (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .enable_i(clk_en_i),
        .level_i(assembly_clear_strobe_i), .rise_o(clr_rise), .fall_o(clr_fall)
    );
    edge_detect u_rcp
    (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .enable_i(clk_en_i),
        .level_i(char_present_flag), .rise_o(), .fall_o(present_fall)
    );
    edge_detect u_shf
    (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .enable_i(clk_en_i),
        .level_i(shift_flag), .rise_o(), .fall_o(shift_fall)
    );
    edge_detect u_lg
    (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .enable_i(clk_en_i),
        .level_i(record_end_gate_i), .rise_o(gate_rise), .fall_o()
    );

    // Parity decode
    wire data_time = ~check_char_time_i & ~longitudinal_char_time_i;
    wire byte_error = char_present_flag & ~byte_parity_ok & data_time;
    wire check_char_parity_error = odd_count ? byte_parity_ok : ~byte_parity_ok;
    wire fwd_check_error = check_char_parity_error & char_present_flag & check_char_time_i
        & forward_dir & read_active & ~longitudinal_char_time_i;
    wire rev_gate_error = gate_rise & backward_dir & read_active & ~odd_count;
    wire char_error = ((read_active | write_active) & byte_error) | fwd_check_error;
    wire rev_preset = backward_dir & char_present_flag & check_char_time_i & byte_parity_ok;
    wire odd_clock = present_fall & ((forward_dir & ~backward_dir)
        | (backward_dir & data_time));
    wire next_pe = (pe_state == PE_IDLE) & char_error;

    // Assembly register
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i | register_clear_i)
            assembly_bit <= '0;
        else if (clk_en_i & ch_fall)
        begin
            if (clear_pending)
                assembly_bit <= '0;
            else
                assembly_bit <= assembly_bit | read_bit_line_i;
        end
    end

    // Clear armed once per strobe, so the next character is not wiped too
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
            clear_pending <= 1'b0;
        else if (clk_en_i)
        begin
            if (clr_rise)
                clear_pending <= 1'b1;
            else if (ch_fall)
                clear_pending <= 1'b0;
        end
    end

    // Read register; end strobe comes from the external period counter
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i | register_clear_i)
            read_reg_bit <= '0;
        else if (end_fall)
            read_reg_bit <= assembly_bit;
    end

    // Memory cycle shift flag
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
            shift_flag <= 1'b0;
        else if (clk_en_i)
        begin
            if (shift_set_i)
                shift_flag <= 1'b1;
            else if (shift_end_i)
                shift_flag <= 1'b0;
        end
    end

    // Character present flag
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i | register_clear_i)
            char_present_flag <= 1'b0;
        else if (clr_fall)
            char_present_flag <= 1'b1;
        else if (shift_fall & read_active)
            char_present_flag <= 1'b0;
    end

    // Byte count parity
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i | count_clear_i)
            odd_count <= 1'b0;
        else if (clk_en_i & rev_preset)
            odd_count <= 1'b1;
        else if (odd_clock)
            odd_count <= ~odd_count;
    end

    // One error pulse per character slot
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            pe_state <= PE_IDLE;
            pe_q <= 1'b0;
        end
        else if (clk_en_i)
        begin
            pe_q <= next_pe | rev_gate_error;
            unique case (pe_state)
                PE_IDLE: if (char_error) pe_state <= PE_HOLD;
                PE_HOLD: pe_state <= PE_WAIT;
                PE_WAIT: if (~char_present_flag) pe_state <= PE_IDLE;
                default: pe_state <= PE_IDLE;
            endcase
        end
    end

    assign parity_error_out_o = pe_q;
    assign data_bus_o = {TRACK_N{pe_q}};
    assign ep_parity_in_o = pe_q;
    assign check_char_parity_error_o = check_char_parity_error;
    assign char_present_flag_o = char_present_flag;
    assign read_reg_o = read_reg_bit;

    // AXI4-Lite write path
    wire do_write = aw_held & w_held & ~bvalid;
    wire [7:0] wa = aw_addr;
    wire wr_ctl = do_write & (wa == OFF_CONTROL);
    wire wr_ist = do_write & (wa == OFF_IRQ_STATUS);
    wire wr_msk = do_write & (wa == OFF_IRQ_MASK);
    wire wr_ok = wr_ctl | wr_ist | wr_msk;
    wire [IRQ_W-1:0] irq_event = {clr_fall, pe_q};
    wire [IRQ_W-1:0] irq_clear = wr_ist ? w_data[IRQ_W-1:0] : '0;
    assign s_axi_awready = ~aw_held;
    assign s_axi_wready = ~w_held;
    assign s_axi_bvalid = bvalid;
    assign s_axi_bresp = bresp;

    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid & ~aw_held)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid & ~w_held)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end
            else if (bvalid & s_axi_bready)
                bvalid <= 1'b0;
        end
    end

    // Control, mask and sticky status; a new event wins over its clear
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            control <= CTL_RESET;
            irq_mask <= '0;
            irq_status <= '0;
        end
        else
        begin
            if (wr_ctl & w_strb[0])
                control[7:0] <= w_data[7:0];
            if (wr_msk & w_strb[0])
                irq_mask <= w_data[IRQ_W-1:0];
            irq_status <= (irq_status & ~irq_clear) | irq_event;
        end
    end
    assign irq_o = |(irq_status & irq_mask);

    // AXI4-Lite read path
    wire [31:0] status_word = {27'h0, check_char_parity_error, byte_parity_ok,
        shift_flag, odd_count, char_present_flag};
    wire rd_hit = (s_axi_araddr == OFF_CONTROL) | (s_axi_araddr == OFF_STATUS)
        | (s_axi_araddr == OFF_IRQ_STATUS) | (s_axi_araddr == OFF_IRQ_MASK)
        | (s_axi_araddr == OFF_READ_REG);
    wire [31:0] rd_word =
        (s_axi_araddr == OFF_CONTROL) ? control :
        (s_axi_araddr == OFF_STATUS) ? status_word :
        (s_axi_araddr == OFF_IRQ_STATUS) ? {30'h0, irq_status} :
        (s_axi_araddr == OFF_IRQ_MASK) ? {30'h0, irq_mask} :
        (s_axi_araddr == OFF_READ_REG) ? {23'h0, read_reg_bit} : 32'h0000_0000;
    assign s_axi_arready = ~rvalid;
    assign s_axi_rvalid = rvalid;
    assign s_axi_rdata = rdata;
    assign s_axi_rresp = rresp;

    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= RESP_OKAY;
        end
        else if (s_axi_arvalid & ~rvalid)
        begin
            rvalid <= 1'b1;
            rdata <= rd_word;
            rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rvalid & s_axi_rready)
            rvalid <= 1'b0;
    end

    a_copy_on_end: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        end_fall & ~register_clear_i |=> read_reg_bit == $past(assembly_bit))
        else $error("read register missed assembly copy");
    a_present_set: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        clr_fall & ~register_clear_i |=> char_present_flag)
        else $error("present flag not set");
    a_present_clear: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        shift_fall & read_active & ~clr_fall & ~register_clear_i |=> ~char_present_flag)
        else $error("present flag not cleared");
    a_odd_toggle: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        odd_clock & ~count_clear_i & ~rev_preset |=> odd_count != $past(odd_count))
        else $error("byte count parity did not toggle");
    a_no_lrc_toggle: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        backward_dir & ~forward_dir & longitudinal_char_time_i & ~count_clear_i & ~rev_preset
        |=> odd_count == $past(odd_count))
        else $error("byte count toggled at longitudinal time");
    a_pe_pulse: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        $rose(pe_q) & ~rev_gate_error |=> ~pe_q)
        else $error("parity error longer than one cycle");
    a_gate_error: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        clk_en_i & rev_gate_error |=> parity_error_out_o && data_bus_o == '1)
        else $error("backward gate error not reported");
    a_data_error: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        clk_en_i & read_active & byte_error & (pe_state == PE_IDLE) |=> ep_parity_in_o)
        else $error("bad byte not reported");
endmodule

/* File: testbench/read_channel_model.sv */
`timescale 1ns/1ps
// Read channel side: deskew bits, channel clock and assembly strobes
module read_channel_model
(
    // Clock
    input wire logic ref_clk_i,
    // Channel outputs
    output logic [8:0] read_bit_line_o,
    output logic channel_clock_o,
    output logic assembly_end_strobe_o,
    output logic assembly_clear_strobe_o
);
    initial
    begin
        read_bit_line_o = 9'h000;
        channel_clock_o = 1'h0;
        assembly_end_strobe_o = 1'h0;
        assembly_clear_strobe_o = 1'h0;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask
    // One character slot; zero bits and idle tracks leave a line low
    task automatic send_char(input logic [8:0] d);
        read_bit_line_o <= d;
        hold(2);
        channel_clock_o <= 1'h1;
        hold(2);
        channel_clock_o <= 1'h0;
        hold(2);
        read_bit_line_o <= 9'h000;
        assembly_end_strobe_o <= 1'h1;
        hold(2);
        assembly_end_strobe_o <= 1'h0;
        hold(1);
        assembly_clear_strobe_o <= 1'h1;
        hold(1);
        channel_clock_o <= 1'h1;
        hold(2);
        channel_clock_o <= 1'h0;
        hold(2);
        assembly_clear_strobe_o <= 1'h0;
        hold(1);
    endtask
endmodule

/* File: testbench/tape_read_char_parity_check_tb_top.sv */
`timescale 1ns/1ps
module tape_read_char_parity_check_tb_top;
    import tape_read_pkg::*;
    logic ref_clk = 1'h0;
    logic reset = 1'h1;
    logic ct = 1'h0, lt = 1'h0, gate = 1'h0, sh_set = 1'h0, sh_end = 1'h0;
    logic reg_clr = 1'h0, cnt_clr = 1'h0;
    logic [8:0] bits, data_bus, read_reg;
    logic chclk, end_st, clr_st, pe, ep_in, ce, present, irq;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic awready, wready, bvalid, arready, rvalid, i0, i1;
    logic [1:0] bresp, rresp, r;
    logic [8:0] fwd_bytes [7] = '{9'h003, 9'h018, 9'h180, 9'h000, 9'h049, 9'h001, 9'h1ff};
    int n_errors = 0, compares = 0, pe_cnt = 0;
    initial forever #4 ref_clk = ~ref_clk;
    read_channel_model chan (.ref_clk_i(ref_clk), .read_bit_line_o(bits),
        .channel_clock_o(chclk), .assembly_end_strobe_o(end_st),
        .assembly_clear_strobe_o(clr_st));
    tape_read_char_parity_check DUT (.ref_clk_i(ref_clk), .reset_i(reset), .clk_en_i(1'h1),
        .read_bit_line_i(bits), .channel_clock_i(chclk), .assembly_end_strobe_i(end_st),
        .assembly_clear_strobe_i(clr_st), .shift_set_i(sh_set), .shift_end_i(sh_end),
        .check_char_time_i(ct), .longitudinal_char_time_i(lt), .record_end_gate_i(gate),
        .register_clear_i(reg_clr), .count_clear_i(cnt_clr), .data_bus_o(data_bus),
        .parity_error_out_o(pe), .ep_parity_in_o(ep_in), .check_char_parity_error_o(ce),
        .char_present_flag_o(present), .read_reg_o(read_reg), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .irq_o(irq));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic timeout();
        n_errors++;
        $display("CHECK FAILED wait expected done seen timeout");
        close_out();
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // Error output and its copies on the bus and pattern input
    always @(posedge ref_clk)
    begin
        if (!reset)
        begin
            chk("data_bus", {23'h0, {9{pe}}}, {23'h0, data_bus});
            chk("ep_in", {31'h0, pe}, {31'h0, ep_in});
            if (pe === 1'h1) pe_cnt++;
        end
    end
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
        int i;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (i = 0; i < 40; i++)
        begin
            @(posedge ref_clk);
            if (awready & awvalid) awvalid <= 1'h0;
            if (wready & wvalid) wvalid <= 1'h0;
            if (bvalid)
            begin
                bready <= 1'h0;
                break;
            end
        end
        @(posedge ref_clk);
        if (i == 40) timeout();
    endtask
    task automatic axi_rd(input logic [7:0] a);
        int i;
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (i = 0; i < 40; i++)
        begin
            @(posedge ref_clk);
            if (arready & arvalid) arvalid <= 1'h0;
            if (rvalid)
            begin
                d = rdata;
                r = rresp;
                rready <= 1'h0;
                break;
            end
        end
        @(posedge ref_clk);
        if (i == 40) timeout();
    endtask
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] m,
        input logic [31:0] exp);
        axi_rd(a);
        chk(what, exp, d & m);
    endtask
    task automatic clr_count();
        cnt_clr <= 1'h1;
        step(1);
        cnt_clr <= 1'h0;
        step(1);
    endtask
    // Character slot with memory-cycle shift between characters
    task automatic char_slot(input logic [8:0] v, input logic c, input logic l,
        input int exp_pe, input logic exp_ce);
        int start;
        start = pe_cnt;
        ct <= c;
        lt <= l;
        chan.send_char(v);
        step(2);
        chk("read_reg", {23'h0, v}, {23'h0, read_reg});
        chk("present", 32'h1, {31'h0, present});
        if (c) chk("check_err", {31'h0, exp_ce}, {31'h0, ce});
        sh_set <= 1'h1;
        step(1);
        sh_set <= 1'h0;
        step(2);
        sh_end <= 1'h1;
        step(1);
        sh_end <= 1'h0;
        step(3);
        chk("present", 32'h0, {31'h0, present});
        chk("pe_count", exp_pe, pe_cnt - start);
        ct <= 1'h0;
        lt <= 1'h0;
        step(1);
    endtask
    task automatic t_reset();
        chk("read_reg", 32'h0, {23'h0, read_reg});
        chk("present", 32'h0, {31'h0, present});
        rd_chk("control", OFF_CONTROL, 32'hffff_ffff, CTL_RESET);
        rd_chk("unmapped", 8'h20, 32'hffff_ffff, 32'h0);
        chk("unmapped_resp", {30'h0, RESP_SLVERR}, {30'h0, r});
        $display("test reset done");
    endtask
    task automatic t_forward();
        axi_wr(OFF_CONTROL, 32'h0000_0005);
        rd_chk("control", OFF_CONTROL, 32'hf, 32'h5);
        foreach (fwd_bytes[k])
            char_slot(fwd_bytes[k], 1'h0, 1'h0, (^fwd_bytes[k]) ? 0 : 1, 1'h0);
        rd_chk("odd", OFF_STATUS, 32'h1 << ST_ODD, 32'h1 << ST_ODD);
        rd_chk("read_reg", OFF_READ_REG, 32'h1ff, 32'h1ff);
        axi_wr(OFF_READ_REG, 32'h0);
        rd_chk("read_reg_ro", OFF_READ_REG, 32'h1ff, 32'h1ff);
        rd_chk("irq_status", OFF_IRQ_STATUS, 32'h3, 32'h3);
        axi_wr(OFF_IRQ_MASK, 32'h0);
        step(2);
        i0 = irq;
        axi_wr(OFF_IRQ_MASK, 32'h3);
        step(2);
        i1 = irq;
        chk("irq_mask", 32'h1, {31'h0, i0 ^ i1});
        axi_wr(OFF_IRQ_STATUS, 32'h3);
        rd_chk("irq_clear", OFF_IRQ_STATUS, 32'h3, 32'h0);
        chk("irq", 32'h0, {31'h0, irq});
        char_slot(9'h0ff, 1'h1, 1'h0, 0, 1'h0);
        char_slot(9'h003, 1'h0, 1'h1, 0, 1'h0);
        clr_count();
        char_slot(9'h010, 1'h0, 1'h0, 0, 1'h0);
        char_slot(9'h007, 1'h1, 1'h0, 1, 1'h1);
        $display("test forward done");
    endtask
    task automatic t_backward();
        logic [8:0] cb [4] = '{9'h001, 9'h001, 9'h003, 9'h003};
        int nd [4] = '{2, 1, 1, 0};
        int start;
        axi_wr(OFF_CONTROL, 32'h0000_0009);
        for (int k = 0; k < 4; k++)
        begin
            clr_count();
            char_slot(9'h003, 1'h0, 1'h1, 0, 1'h0);
            char_slot(cb[k], 1'h1, 1'h0, 0, 1'h1);
            for (int j = 0; j < nd[k]; j++)
                char_slot(9'h001 << j, 1'h0, 1'h0, 0, 1'h0);
            start = pe_cnt;
            gate <= 1'h1;
            step(3);
            gate <= 1'h0;
            step(3);
            chk("gate_pe", ((^cb[k]) ^ nd[k][0]) ? 0 : 1, pe_cnt - start);
        end
        $display("test backward done");
    endtask
    task automatic t_clear();
        int start;
        axi_wr(OFF_CONTROL, 32'h0000_0002);
        start = pe_cnt;
        chan.send_char(9'h003);
        step(3);
        chk("write_pe", 32'h1, pe_cnt - start);
        chk("present_set", 32'h1, {31'h0, present});
        reg_clr <= 1'h1;
        step(2);
        reg_clr <= 1'h0;
        step(2);
        chk("read_reg", 32'h0, {23'h0, read_reg});
        chk("present", 32'h0, {31'h0, present});
        $display("test clear done");
    endtask
    initial
    begin
        step(12);
        reset <= 1'h0;
        step(1);
        t_reset();
        t_forward();
        t_backward();
        t_clear();
        close_out();
    end
    initial
    begin
        #400000;
        timeout();
    end
endmodule
